// ==== verilog/mms_pkg.sv ====
// constants, encodings and reset values of the control method select block
// assumes registers are reached over a plain strobe port with 16-bit data
`default_nettype none

package mms_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam int TERM_N = 7;

    // register indices
    localparam logic [4:0] OFS_CAPACITY   = 5'h00;
    localparam logic [4:0] OFS_POLES      = 5'h01;
    localparam logic [4:0] OFS_METHOD     = 5'h02;
    localparam logic [4:0] OFS_BOOST      = 5'h03;
    localparam logic [4:0] OFS_ALT_BOOST  = 5'h04;
    localparam logic [4:0] OFS_MOTOR_TYPE = 5'h05;
    localparam logic [4:0] OFS_GROUP_SEL  = 5'h06;
    localparam logic [4:0] OFS_STATUS     = 5'h07;
    localparam logic [4:0] OFS_MAP_BASE   = 5'h08;

    // status register fields
    localparam int STAT_VF_BIT     = 0;
    localparam int STAT_ADV_BIT    = 1;
    localparam int STAT_GP_BIT     = 2;
    localparam int STAT_SECOND_BIT = 3;
    localparam int STAT_SWITCH_BIT = 4;
    localparam int STAT_RUN_BIT    = 5;

    // reserved value meaning "not set"
    localparam logic [15:0] RESERVED_VALUE = 16'h270F;

    // capacity in 0.01 kW units, boost in 0.1 % units
    localparam logic [15:0] CAPACITY_MIN = 16'h000A;
    localparam logic [15:0] CAPACITY_MAX = 16'h05DC;
    localparam logic [15:0] POLES_MAX    = 16'h000A;
    localparam logic [15:0] BOOST_MAX    = 16'h012C;
    localparam logic [15:0] BOOST_3PCT   = 16'h001E;
    localparam logic [15:0] BOOST_2PCT   = 16'h0014;

    localparam logic [15:0] METHOD_ADVANCED = 16'h0014;
    localparam logic [15:0] METHOD_GENERAL  = 16'h001E;
    localparam logic [15:0] MAP_CODE_SWITCH = 16'h0012;
    localparam logic [15:0] MAP_MAX         = 16'h270F;

    // reset values
    localparam logic [15:0] RST_CAPACITY   = 16'h270F;
    localparam logic [15:0] RST_POLES      = 16'h270F;
    localparam logic [15:0] RST_METHOD     = 16'h0014;
    localparam logic [15:0] RST_BOOST      = 16'h001E;
    localparam logic [15:0] RST_ALT_BOOST  = 16'h270F;
    localparam logic [15:0] RST_MOTOR_TYPE = 16'h0000;
    localparam logic [15:0] RST_GROUP_SEL  = 16'h0000;
    localparam logic [15:0] RST_MAP        = 16'h270F;

    // active control method, one-hot
    typedef enum logic [2:0] {
        MMS_VF       = 3'b001,
        MMS_ADVANCED = 3'b010,
        MMS_GENERAL  = 3'b100
    } mms_method_type;

endpackage

`default_nettype wire

// ==== verilog/mms_method_decode.sv ====
// control method decoder: settings and switchover input to a method
// assumes settings are already range checked by the register file
`timescale 1ns/1ps
`default_nettype none

module mms_method_decode
(
    input  wire logic [15:0]            capacity,
    input  wire logic [15:0]            poles,
    input  wire logic [15:0]            method_code,
    input  wire logic                   vf_switchover_input,
    output mms_pkg::mms_method_type     method
);

    wire motor_unset;
    wire want_adv;
    wire want_gp;

    assign motor_unset = (capacity == mms_pkg::RESERVED_VALUE)
                       | (poles == mms_pkg::RESERVED_VALUE); // [RQ1]
    assign want_adv = (method_code == mms_pkg::METHOD_ADVANCED); // [RQ2]
    assign want_gp  = (method_code == mms_pkg::METHOD_GENERAL); // [RQ3]

    always_comb
    begin
        if (motor_unset | vf_switchover_input) // [RQ1] [RQ6]
            method = mms_pkg::MMS_VF;
        else if (want_gp)
            method = mms_pkg::MMS_GENERAL; // [RQ3]
        else if (want_adv)
            method = mms_pkg::MMS_ADVANCED; // [RQ2]
        else
            method = mms_pkg::MMS_VF;
    end

endmodule

`default_nettype wire

// ==== verilog/mms_method_select.sv ====
// control method select and manual torque boost gating
// assumes terminal inputs, run and second-function inputs are synchronous
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RQ1] reserved capacity or poles forces V/f
// [RQ2] code 20 with motor set: advanced vector
// [RQ3] code 30 with motor set: general vector
// [RQ4] reset: motor unset, code 20, V/f
// [RQ5] accept capacity 0.1-15 kW, poles 2-10 even
// [RQ6] switchover input forces V/f over vector
// [RQ7] switchover comes from terminals mapped 18
// [RQ8] switchover to V/f also selects second set
// [RQ9] no method change while running
// [RQ10] primary boost 0-30 percent, zero-hertz voltage
// [RQ11] second input uses second boost, reserved disables
// [RQ12] second input enables all second functions
// [RQ13] boost applied only under V/f
// [RQ14] boost 3 to 2 on constant-torque motor
// [RQ15] second boost reachable only with group zero
// [RQ16] out-of-range writes leave value unchanged
module mms_method_select
#(
    parameter int TERM_N = mms_pkg::TERM_N
)
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [4:0]           reg_addr,
    input  wire logic [15:0]          reg_wdata,
    input  wire logic                 reg_write,
    input  wire logic                 reg_read,
    output logic      [15:0]          reg_rdata,
    input  wire logic [TERM_N-1:0]    terminal_in,
    input  wire logic                 second_function_select,
    input  wire logic                 drive_running,
    output logic                      vf_active,
    output logic                      advanced_active,
    output logic                      general_active,
    output logic                      second_function_active,
    output logic      [15:0]          applied_boost
);

    // stored settings
    logic [15:0] motor_capacity_setting;
    logic [15:0] motor_pole_count;
    logic [15:0] control_method_code;
    logic [15:0] torque_boost_percent;
    logic [15:0] alternate_torque_boost;
    logic [15:0] applied_motor_type;
    logic [15:0] parameter_group_read_select;
    logic [15:0] input_terminal_function_map [TERM_N];

    mms_pkg::mms_method_type active_method;
    mms_pkg::mms_method_type decoded_method;
    mms_pkg::mms_method_type next_method;

    function automatic logic is_constant_torque(input logic [15:0] code);
        is_constant_torque = (code == 16'h0001) | (code == 16'h000D)
                           | (code == 16'h0032) | (code == 16'h0035);
    endfunction

    function automatic logic motor_type_ok(input logic [15:0] code);
        motor_type_ok = (code <= 16'h0001)
                      | ((code >= 16'h0003) & (code <= 16'h0006))
                      | ((code >= 16'h000D) & (code <= 16'h0010))
                      | (code == 16'h0017) | (code == 16'h0018)
                      | (code == 16'h0028) | (code == 16'h002B)
                      | (code == 16'h002C) | (code == 16'h0032)
                      | (code == 16'h0035) | (code == 16'h0036);
    endfunction

    // range checks
    wire cap_ok;
    wire poles_ok;
    wire method_ok;
    wire boost_ok;
    wire alt_ok;
    wire type_ok;
    wire map_ok;

    assign cap_ok = (reg_wdata == mms_pkg::RESERVED_VALUE)
                  | ((reg_wdata >= mms_pkg::CAPACITY_MIN)
                  & (reg_wdata <= mms_pkg::CAPACITY_MAX)); // [RQ5]
    assign poles_ok = (reg_wdata == mms_pkg::RESERVED_VALUE)
                    | ((reg_wdata != 16'h0000) & ~reg_wdata[0]
                    & (reg_wdata <= mms_pkg::POLES_MAX)); // [RQ5]
    assign method_ok = (reg_wdata == mms_pkg::METHOD_ADVANCED)
                     | (reg_wdata == mms_pkg::METHOD_GENERAL);
    assign boost_ok = (reg_wdata <= mms_pkg::BOOST_MAX); // [RQ10]
    assign alt_ok = boost_ok
                  | (reg_wdata == mms_pkg::RESERVED_VALUE); // [RQ11]
    assign type_ok = motor_type_ok(reg_wdata);
    assign map_ok = (reg_wdata <= mms_pkg::MAP_MAX);

    // address decode
    wire group_zero;
    wire map_hit;
    wire [4:0] map_index;

    assign group_zero = (parameter_group_read_select == 16'h0000);
    assign map_index = reg_addr - mms_pkg::OFS_MAP_BASE;
    assign map_hit = (reg_addr >= mms_pkg::OFS_MAP_BASE)
                   & (map_index < 5'(TERM_N));

    wire wr_cap;
    wire wr_poles;
    wire wr_method;
    wire wr_boost;
    wire wr_alt;
    wire wr_type;
    wire wr_group;
    wire wr_map;

    assign wr_cap = reg_write & (reg_addr == mms_pkg::OFS_CAPACITY)
                  & cap_ok; // [RQ16]
    assign wr_poles = reg_write & (reg_addr == mms_pkg::OFS_POLES)
                    & poles_ok; // [RQ16]
    assign wr_method = reg_write & (reg_addr == mms_pkg::OFS_METHOD)
                     & method_ok; // [RQ16]
    assign wr_boost = reg_write & (reg_addr == mms_pkg::OFS_BOOST)
                    & boost_ok; // [RQ16]
    assign wr_alt = reg_write & (reg_addr == mms_pkg::OFS_ALT_BOOST)
                  & alt_ok & group_zero; // [RQ15] [RQ16]
    assign wr_type = reg_write & (reg_addr == mms_pkg::OFS_MOTOR_TYPE)
                   & type_ok; // [RQ16]
    assign wr_group = reg_write & (reg_addr == mms_pkg::OFS_GROUP_SEL)
                    & map_ok; // [RQ16]
    assign wr_map = reg_write & map_hit & map_ok; // [RQ16]

    // boost rewrite on a change to a constant-torque motor
    wire type_changes;
    wire boost_autofix;

    assign type_changes = wr_type & (reg_wdata != applied_motor_type);
    assign boost_autofix = type_changes & is_constant_torque(reg_wdata)
                         & (torque_boost_percent == mms_pkg::BOOST_3PCT);

    // switchover terminal routing
    logic switchover_level;

    always_comb
    begin
        switchover_level = 1'b0;
        for (int i = 0; i < TERM_N; i++)
        begin
            if (input_terminal_function_map[i] == mms_pkg::MAP_CODE_SWITCH)
                switchover_level = switchover_level | terminal_in[i]; // [RQ7]
        end
    end

    mms_method_decode u_decode
    (
        .capacity            (motor_capacity_setting),
        .poles               (motor_pole_count),
        .method_code         (control_method_code),
        .vf_switchover_input (switchover_level),
        .method              (decoded_method)
    );

    // hold the method while running
    assign next_method = drive_running ? active_method
                                       : decoded_method; // [RQ9]

    // second set: terminal input or switchover, also during running
    wire next_second;

    assign next_second = second_function_select
                       | switchover_level; // [RQ8] [RQ9] [RQ12]

    // boost gating
    wire next_vf;
    wire use_alt;
    wire [15:0] next_boost;

    assign next_vf = (next_method == mms_pkg::MMS_VF);
    assign use_alt = next_second
                   & (alternate_torque_boost != mms_pkg::RESERVED_VALUE);
    assign next_boost = !next_vf ? 16'h0000 // [RQ13]
                      : use_alt ? alternate_torque_boost // [RQ11]
                      : torque_boost_percent; // [RQ10]

    // read mux
    wire [15:0] status_word;
    logic [15:0] next_rdata;

    assign status_word = {10'h000, drive_running, switchover_level,
                          second_function_active, active_method};

    always_comb
    begin
        next_rdata = 16'h0000;
        case (reg_addr)
            mms_pkg::OFS_CAPACITY:   next_rdata = motor_capacity_setting;
            mms_pkg::OFS_POLES:      next_rdata = motor_pole_count;
            mms_pkg::OFS_METHOD:     next_rdata = control_method_code;
            mms_pkg::OFS_BOOST:      next_rdata = torque_boost_percent;
            mms_pkg::OFS_ALT_BOOST:
                next_rdata = group_zero ? alternate_torque_boost
                                        : 16'h0000; // [RQ15]
            mms_pkg::OFS_MOTOR_TYPE: next_rdata = applied_motor_type;
            mms_pkg::OFS_GROUP_SEL:  next_rdata = parameter_group_read_select;
            mms_pkg::OFS_STATUS:     next_rdata = status_word;
            default:
            begin
                if (map_hit)
                    next_rdata = input_terminal_function_map[map_index[2:0]];
                else
                    next_rdata = 16'h0000;
            end
        endcase
    end

    // settings
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            motor_capacity_setting <= mms_pkg::RST_CAPACITY; // [RQ4]
            motor_pole_count       <= mms_pkg::RST_POLES; // [RQ4]
            control_method_code    <= mms_pkg::RST_METHOD; // [RQ4]
        end
        else
        begin
            if (wr_cap)
                motor_capacity_setting <= reg_wdata;
            if (wr_poles)
                motor_pole_count <= reg_wdata;
            if (wr_method)
                control_method_code <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            torque_boost_percent        <= mms_pkg::RST_BOOST;
            alternate_torque_boost      <= mms_pkg::RST_ALT_BOOST;
            applied_motor_type          <= mms_pkg::RST_MOTOR_TYPE;
            parameter_group_read_select <= mms_pkg::RST_GROUP_SEL;
        end
        else
        begin
            if (boost_autofix)
                torque_boost_percent <= mms_pkg::BOOST_2PCT; // [RQ14]
            else if (wr_boost)
                torque_boost_percent <= reg_wdata;
            if (wr_alt)
                alternate_torque_boost <= reg_wdata;
            if (wr_type)
                applied_motor_type <= reg_wdata;
            if (wr_group)
                parameter_group_read_select <= reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < TERM_N; i++)
                input_terminal_function_map[i] <= mms_pkg::RST_MAP;
        end
        else if (wr_map)
        begin
            input_terminal_function_map[map_index[2:0]] <= reg_wdata;
        end
    end

    // active method state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            active_method <= mms_pkg::MMS_VF; // [RQ4]
        else
        begin
            case (next_method)
                mms_pkg::MMS_VF:       active_method <= mms_pkg::MMS_VF;
                mms_pkg::MMS_ADVANCED: active_method <= mms_pkg::MMS_ADVANCED;
                mms_pkg::MMS_GENERAL:  active_method <= mms_pkg::MMS_GENERAL;
                default:               active_method <= mms_pkg::MMS_VF;
            endcase
        end
    end

    // registered outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            vf_active              <= 1'b1;
            advanced_active        <= 1'b0;
            general_active         <= 1'b0;
            second_function_active <= 1'b0;
            applied_boost          <= 16'h0000;
            reg_rdata              <= 16'h0000;
        end
        else
        begin
            vf_active              <= next_vf;
            advanced_active        <= (next_method == mms_pkg::MMS_ADVANCED);
            general_active         <= (next_method == mms_pkg::MMS_GENERAL);
            second_function_active <= next_second;
            applied_boost          <= next_boost;
            reg_rdata              <= reg_read ? next_rdata : 16'h0000;
        end
    end

endmodule

`default_nettype wire

// ==== test/mms_sva.sv ====
// assertions on the ports of the control method select block
// assumes the register map and codes of mms_pkg
`timescale 1ns/1ps
`default_nettype none

module mms_sva
#(
    parameter int TERM_N = 7
)
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [4:0]        reg_addr,
    input wire logic [15:0]       reg_wdata,
    input wire logic              reg_write,
    input wire logic [TERM_N-1:0] terminal_in,
    input wire logic              second_function_select,
    input wire logic              drive_running,
    input wire logic              vf_active,
    input wire logic              advanced_active,
    input wire logic              general_active,
    input wire logic              second_function_active,
    input wire logic [15:0]       applied_boost
);
    logic              cap_ok;
    logic              pol_ok;
    logic              gp_sel;
    logic [TERM_N-1:0] sw_mask;
    wire logic [15:0]  d = reg_wdata;
    wire logic [4:0]   mi = reg_addr - mms_pkg::OFS_MAP_BASE;
    wire logic         rsv = d == mms_pkg::RESERVED_VALUE;
    wire logic         cap_in = d >= mms_pkg::CAPACITY_MIN
                             && d <= mms_pkg::CAPACITY_MAX;
    wire logic         pol_in = d != 16'h0000 && !d[0]
                             && d <= mms_pkg::POLES_MAX;
    wire logic         gp_in = d == mms_pkg::METHOD_GENERAL;
    wire logic         meth_in = gp_in || d == mms_pkg::METHOD_ADVANCED;
    wire logic         sw = |(terminal_in & sw_mask);
    wire logic         motor_set = cap_ok && pol_ok;

    // shadow of the settings that pick the method
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cap_ok   <= 1'b0;
            pol_ok   <= 1'b0;
            gp_sel   <= 1'b0;
            sw_mask  <= '0;
        end
        else if (reg_write)
        begin
            if (reg_addr == mms_pkg::OFS_CAPACITY && (cap_in || rsv))
                cap_ok <= cap_in;
            if (reg_addr == mms_pkg::OFS_POLES && (pol_in || rsv))
                pol_ok <= pol_in;
            if (reg_addr == mms_pkg::OFS_METHOD && meth_in)
                gp_sel <= gp_in;
            if (int'(mi) < TERM_N && d <= mms_pkg::MAP_MAX)
                sw_mask[mi] <= d == mms_pkg::MAP_CODE_SWITCH;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_reserved;
        !motor_set && !drive_running |=> vf_active;
    endproperty
    a_reserved: assert property (p_reserved) else $error("not vf");
    property p_adv;
        motor_set && !gp_sel && !sw && !drive_running |=> advanced_active;
    endproperty
    a_adv: assert property (p_adv) else $error("not advanced");
    property p_gp;
        motor_set && gp_sel && !sw && !drive_running |=> general_active;
    endproperty
    a_gp: assert property (p_gp) else $error("not general");
    property p_switch;
        sw && !drive_running |=> vf_active && second_function_active;
    endproperty
    a_switch: assert property (p_switch) else $error("switch");
    property p_second;
        1'b1 |=> second_function_active
            == $past(second_function_select || sw);
    endproperty
    a_second: assert property (p_second) else $error("second");
    property p_freeze;
        drive_running
            |=> $stable({vf_active, advanced_active, general_active});
    endproperty
    a_freeze: assert property (p_freeze) else $error("moved");
    property p_boost_vec;
        advanced_active || general_active |-> applied_boost == 16'h0000;
    endproperty
    a_boost_vec: assert property (p_boost_vec) else $error("boost");
    property p_boost_max;
        applied_boost <= mms_pkg::BOOST_MAX;
    endproperty
    a_boost_max: assert property (p_boost_max) else $error("big");

    c_adv: cover property (advanced_active);
    c_switch: cover property (sw && !drive_running ##1 vf_active);
    c_frozen: cover property (drive_running && sw);
endmodule

bind mms_method_select mms_sva #(.TERM_N(TERM_N)) u_mms_sva (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .terminal_in(terminal_in),
    .second_function_select(second_function_select),
    .drive_running(drive_running), .vf_active(vf_active),
    .advanced_active(advanced_active), .general_active(general_active),
    .second_function_active(second_function_active),
    .applied_boost(applied_boost)
);

`default_nettype wire

// ==== test/mms_terminal_model.sv ====
// terminal strip and run signal of the drive, with a settle lag
// assumes bench requests are held until they show
`timescale 1ns/1ps
`default_nettype none

module mms_terminal_model
#(
    parameter int TERM_N = 7
)
(
    input  wire logic              clk,
    input  wire logic [TERM_N-1:0] want_t,
    input  wire logic              want_s,
    input  wire logic              want_r,
    input  wire logic [1:0]        lag,
    output logic      [TERM_N-1:0] terminal_in,
    output logic                   second_function_select,
    output logic                   drive_running
);
    logic [1:0] wait_cnt;
    wire logic  same = {want_t, want_s, want_r}
                    == {terminal_in, second_function_select, drive_running};

    initial
    begin
        terminal_in = '0;
        second_function_select = 1'b0;
        drive_running = 1'b0;
        wait_cnt = 2'h0;
    end

    // levels follow the request after a short lag
    always @(posedge clk)
    begin
        if (same || wait_cnt != 2'h0)
            wait_cnt <= same ? lag : wait_cnt - 2'h1;
        else
        begin
            terminal_in <= want_t;
            second_function_select <= want_s;
            drive_running <= want_r;
        end
    end
endmodule

`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench of the control method select block
// assumes a 20 MHz clock and the register map of mms_pkg
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        look = 1'b0;
    logic        rd_pend = 1'b0;
    logic [6:0]  want_t = 7'h00;
    logic        want_s = 1'b0;
    logic        want_r = 1'b0;
    logic [1:0]  lag = 2'h0;
    logic [31:0] seed = 32'h0000C042;
    logic [15:0] reg_rdata;
    logic [6:0]  terminal_in;
    logic        second_function_select;
    logic        drive_running;
    wire [2:0]   m;
    logic        second_function_active;
    logic [15:0] applied_boost;
    int          fails = 0;
    int          comparisons = 0;
    logic [15:0] rd_exp[$];
    logic [19:0] out_exp[$];
    logic [15:0] caps[3];
    logic [15:0] rv[16] = '{16'h270F, 16'h270F, 16'h0014, 16'h001E,
        16'h270F, 16'h0000, 16'h0000, 16'h0001, 16'h270F, 16'h270F,
        16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h270F, 16'h0000};
    logic [15:0] bad[4] = '{16'h0009, 16'h000C, 16'h0019, 16'h012D};
    logic [15:0] ct[4] = '{16'h0001, 16'h000D, 16'h0032, 16'h0035};

    mms_method_select #(.TERM_N(7)) u_mms_method_select (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .terminal_in(terminal_in),
        .second_function_select(second_function_select),
        .drive_running(drive_running), .vf_active(m[2]),
        .advanced_active(m[1]), .general_active(m[0]),
        .second_function_active(second_function_active),
        .applied_boost(applied_boost)
    );
    mms_terminal_model #(.TERM_N(7)) u_mms_terminal_model (
        .clk(clk), .want_t(want_t), .want_s(want_s), .want_r(want_r),
        .lag(lag), .terminal_in(terminal_in),
        .second_function_select(second_function_select),
        .drive_running(drive_running)
    );

    always #25 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        rd_exp.push_back(e);
        @(posedge clk);
        reg_read <= 1'b0;
    endtask

    // outputs as {vf, advanced, general, second, boost}
    task automatic see(input logic [2:0] mm, input logic s,
                       input logic [15:0] b);
        @(posedge clk);
        look <= 1'b1;
        out_exp.push_back({mm, s, b});
        @(posedge clk);
        look <= 1'b0;
    endtask

    task automatic set_io(input logic [6:0] t, input logic s, input logic r);
        int n;
        n = 0;
        seed = xs(seed);
        @(posedge clk);
        want_t <= t;
        want_s <= s;
        want_r <= r;
        lag <= seed[1:0];
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while ({terminal_in, second_function_select, drive_running}
               !== {t, s, r} && n < 20);
        if (n >= 20)
            fails++;
    endtask

    task automatic test_done;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // watcher: compares each result against the oldest note
    always @(posedge clk)
    begin
        if (rd_pend)
            chk({4'h0, reg_rdata}, {4'h0, rd_exp.pop_front()});
        if (look)
            chk({m, second_function_active, applied_boost},
                out_exp.pop_front());
        rd_pend = reg_read;
    end

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 16; a++)
            rd(a[4:0], rv[a]);
        see(3'b100, 1'b0, 16'h001E);
        for (int i = 0; i < 4; i++)
        begin
            wr(i[4:0], bad[i]);
            rd(i[4:0], rv[i]);
        end
        wr(5'h0F, 16'h1234);
        rd(5'h0F, 16'h0000);
        seed = xs(seed);
        caps = '{mms_pkg::CAPACITY_MIN, mms_pkg::CAPACITY_MAX,
                 mms_pkg::CAPACITY_MIN + 16'(seed % 1491)};
        for (int i = 0; i < 3; i++)
        begin
            wr(5'h00, caps[i]);
            rd(5'h00, caps[i]);
        end
        see(3'b100, 1'b0, 16'h001E);
        for (int p = 2; p <= 10; p += 2)
        begin
            wr(5'h01, 16'(p));
            rd(5'h01, 16'(p));
        end
        see(3'b010, 1'b0, 16'h0000);
        wr(5'h02, 16'h001E);
        see(3'b001, 1'b0, 16'h0000);
        wr(5'h01, 16'h270F);
        see(3'b100, 1'b0, 16'h001E);
        wr(5'h01, 16'h0004);
        wr(5'h0B, 16'h0012);
        set_io(7'h04, 1'b0, 1'b0);
        see(3'b001, 1'b0, 16'h0000);
        set_io(7'h08, 1'b0, 1'b0);
        see(3'b100, 1'b1, 16'h001E);
        wr(5'h03, 16'h0032);
        wr(5'h04, 16'h0064);
        see(3'b100, 1'b1, 16'h0064);
        set_io(7'h00, 1'b1, 1'b0);
        see(3'b001, 1'b1, 16'h0000);
        set_io(7'h00, 1'b0, 1'b1);
        wr(5'h02, 16'h0014);
        set_io(7'h08, 1'b0, 1'b1);
        see(3'b001, 1'b1, 16'h0000);
        set_io(7'h08, 1'b0, 1'b0);
        see(3'b100, 1'b1, 16'h0064);
        set_io(7'h00, 1'b0, 1'b0);
        see(3'b010, 1'b0, 16'h0000);
        wr(5'h03, 16'h001E);
        wr(5'h05, 16'h0003);
        rd(5'h03, 16'h001E);
        for (int i = 0; i < 4; i++)
        begin
            wr(5'h03, 16'h001E);
            wr(5'h05, ct[i]);
            rd(5'h03, 16'h0014);
        end
        wr(5'h06, 16'h0001);
        rd(5'h04, 16'h0000);
        wr(5'h04, 16'h0010);
        wr(5'h06, 16'h0000);
        rd(5'h04, 16'h0064);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(5'h00, 16'h270F);
        see(3'b100, 1'b0, 16'h001E);
        repeat (4) @(posedge clk);
        test_done;
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        fails++;
        test_done;
    end
endmodule

`default_nettype wire
